// ---- design/slsel_top.sv ----
// Sequence launch selector: start, resume and abort of stored sequences
// from discrete inputs, start and abort also from terminal requests, plus statement echo.
// Assumes a sequence interpreter that takes seq_start/resume/abort pulses,
// reports seq_done and statement strobes, and a terminal that resolves names.
`timescale 1ns/10ps
`default_nettype none
`include "slsel_defines.svh"

module slsel_top
	import slsel_pkg::*;
#(
	parameter int N_INPUTS = `SLSEL_NUM_INPUTS,
	parameter int SEL_BITS = `SLSEL_SEL_BITS,
	parameter int STMT_W   = `SLSEL_STMT_W
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	// General-purpose discrete inputs, bit 0 is input one
	input  wire logic [N_INPUTS-1:0] gp_in,
	// Configuration
	input  wire slsel_assign_type    start_input_assign,
	input  wire slsel_assign_type    abort_input_assign,
	input  wire logic [N_INPUTS-1:0] other_func_mask,
	input  wire logic                start_action_mode,
	input  wire logic                echo_enable,
	// Terminal requests
	input  wire logic                term_run_req,
	input  wire logic [SEL_BITS-1:0] term_run_seq,
	input  wire logic                term_abort_req,
	// Interpreter status
	input  wire logic                seq_done,
	input  wire logic                stmt_valid,
	input  wire logic [STMT_W-1:0]   stmt_code,
	// Interpreter commands
	output logic                     seq_start,
	output logic                     seq_resume,
	output logic                     seq_abort,
	output logic [SEL_BITS-1:0]      seq_number,
	output logic                     seq_running,
	// Terminal echo
	output logic                     echo_valid,
	output logic [STMT_W-1:0]        echo_code
);

	typedef struct packed {
		slsel_state_type     st;
		logic                start_prev;
		logic                start_pulse;
		logic                resume_pulse;
		logic                abort_pulse;
		logic [SEL_BITS-1:0] number;
		logic                echo_pulse;
		logic [STMT_W-1:0]   echo_data;
	} slsel_top_state_type;

	slsel_top_state_type state_r;
	slsel_top_state_type state_nxt;

	logic [N_INPUTS-1:0] gp_sync;
	logic                start_lvl;
	logic                abort_lvl;
	logic                start_rise;
	logic                start_fall;
	logic                abort_any;
	logic [N_INPUTS-1:0] occupied;
	logic [SEL_BITS-1:0] sel_val;

	// Assign codes are four bits wide; more than fifteen inputs cannot be named
	initial begin
		if (N_INPUTS < 1 || N_INPUTS > 15) begin
			$error("slsel_top: N_INPUTS must be 1 to 15");
		end
		if (SEL_BITS < 1 || SEL_BITS > N_INPUTS) begin
			$error("slsel_top: SEL_BITS must be 1 to N_INPUTS");
		end
		if (STMT_W < 1) begin
			$error("slsel_top: STMT_W must be at least one");
		end
	end

	slsel_sync_if #(.W(N_INPUTS)) sync_bus ();

	assign sync_bus.raw = gp_in;
	assign gp_sync      = sync_bus.sync;

	slsel_sync #(
		.W       (N_INPUTS)
	) u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.io      (sync_bus)
	);

	// Code zero or beyond the last input selects nothing
	function automatic logic pick_input(input logic [N_INPUTS-1:0] v, input slsel_assign_type idx);
		logic r;
		r = 1'b0;
		for (int i = 0; i < N_INPUTS; i++) begin
			if (idx == `SLSEL_ASSIGN_W'(i + 1)) begin
				r = v[i];
			end
		end
		return r;
	endfunction : pick_input

	// One-hot mask of the input a code names, zero when unassigned
	function automatic logic [N_INPUTS-1:0] onehot_input(input slsel_assign_type idx);
		logic [N_INPUTS-1:0] r;
		r = '0;
		for (int i = 0; i < N_INPUTS; i++) begin
			if (idx == `SLSEL_ASSIGN_W'(i + 1)) begin
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction : onehot_input

	assign start_lvl  = pick_input(gp_sync, start_input_assign);
	assign abort_lvl  = pick_input(gp_sync, abort_input_assign);
	// Edges come from synchronised levels only; a pulse that spans no rising clock edge is lost
	assign start_rise = start_lvl & ~state_r.start_prev;
	assign start_fall = ~start_lvl & state_r.start_prev;
	assign abort_any  = abort_lvl | term_abort_req;

	// Start and abort pins are functions too, so they drop out of the number
	assign occupied = other_func_mask
		| onehot_input(start_input_assign)
		| onehot_input(abort_input_assign);
	assign sel_val  = gp_sync[SEL_BITS-1:0] & ~occupied[SEL_BITS-1:0];

	always_comb begin
		state_nxt              = state_r;
		// Pulses last one cycle unless set again below
		state_nxt.start_prev   = start_lvl;
		state_nxt.start_pulse  = 1'b0;
		state_nxt.resume_pulse = 1'b0;
		state_nxt.abort_pulse  = 1'b0;
		state_nxt.echo_pulse   = 1'b0;
		unique case (state_r.st)
			SLSEL_IDLE: begin
				// A held abort blocks every launch
				if (abort_any) begin
					state_nxt.st = SLSEL_IDLE;
				end else if (start_rise) begin
					state_nxt.st          = SLSEL_RUN;
					state_nxt.start_pulse = 1'b1;
					state_nxt.number      = sel_val;
				end else if (term_run_req) begin
					state_nxt.st          = SLSEL_RUN;
					state_nxt.start_pulse = 1'b1;
					state_nxt.number      = term_run_seq;
				end
			end
			SLSEL_RUN: begin
				// Abort outranks level release, done and resume
				if (abort_any) begin
					state_nxt.st          = SLSEL_IDLE;
					state_nxt.abort_pulse = 1'b1;
				end else if (start_fall && start_action_mode == `SLSEL_MODE_LEVEL) begin
					state_nxt.st          = SLSEL_IDLE;
					state_nxt.abort_pulse = 1'b1;
				end else if (seq_done) begin
					state_nxt.st = SLSEL_IDLE;
				end else if (start_rise && start_action_mode == `SLSEL_MODE_EDGE) begin
					state_nxt.resume_pulse = 1'b1;
				end
				// Judged apart, so the last statement before an abort is still reported
				if (stmt_valid && echo_enable == `SLSEL_ECHO_ON) begin
					state_nxt.echo_pulse = 1'b1;
					state_nxt.echo_data  = stmt_code;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Every output is a state bit; nothing combinational reaches a pin
	assign seq_start   = state_r.start_pulse;
	assign seq_resume  = state_r.resume_pulse;
	assign seq_abort   = state_r.abort_pulse;
	assign seq_number  = state_r.number;
	assign seq_running = (state_r.st == SLSEL_RUN);
	assign echo_valid  = state_r.echo_pulse;
	assign echo_code   = state_r.echo_data;

	// Checks share the system clock and stay quiet in reset
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_launch;
		seq_start && seq_running ##1 !seq_start;
	endsequence

	sequence s_abort_done;
		seq_abort && !seq_running ##1 !seq_abort;
	endsequence

	// Nothing launched or resumed in the cycle
	sequence s_no_launch;
		!seq_start && !seq_resume;
	endsequence

	AST_PIN_LAUNCH: assert property (
		!seq_running && start_rise && !abort_any |=> s_launch)
		else $error("start edge while idle did not launch");

	AST_PIN_NUMBER: assert property (
		!seq_running && start_rise && !abort_any |=> seq_number == $past(sel_val))
		else $error("launched number differs from selection inputs");

	AST_SEL_MASKED: assert property (
		seq_start && $past(!seq_running) && $past(start_rise)
		|-> (seq_number & $past(occupied[SEL_BITS-1:0])) == '0)
		else $error("input owned by another function entered the number");

	AST_START_MAP: assert property (
		$past(resetn, 3) && start_input_assign == `SLSEL_ASSIGN_NONE && $stable(start_input_assign)
		|-> !start_rise)
		else $error("unassigned start produced an edge");

	AST_EDGE_RESUME: assert property (
		seq_running && start_rise && !abort_any && !seq_done
		&& start_action_mode == `SLSEL_MODE_EDGE |=> seq_resume && seq_running && !seq_start)
		else $error("edge mode start edge did not resume");

	AST_EDGE_FALL_KEEP: assert property (
		seq_running && start_fall && !abort_any && !seq_done
		&& start_action_mode == `SLSEL_MODE_EDGE |=> seq_running && !seq_abort)
		else $error("edge mode start release stopped the sequence");

	AST_LEVEL_FALL_ABORT: assert property (
		seq_running && start_fall && start_action_mode == `SLSEL_MODE_LEVEL |=> s_abort_done)
		else $error("level mode start release did not abort");

	AST_ABORT_STOPS: assert property (
		seq_running && abort_any |=> s_abort_done)
		else $error("abort did not stop the running sequence");

	AST_ABORT_SOURCE: assert property (
		seq_abort |-> $past(abort_any)
		|| ($past(start_fall) && $past(start_action_mode) == `SLSEL_MODE_LEVEL))
		else $error("abort issued without abort input or level-mode release");

	AST_TERM_RUN: assert property (
		!seq_running && term_run_req && !start_rise && !abort_any
		|=> seq_start && seq_number == $past(term_run_seq))
		else $error("terminal run request did not launch its sequence");

	AST_ECHO: assert property (
		seq_running && stmt_valid && echo_enable == `SLSEL_ECHO_ON
		|=> echo_valid && echo_code == $past(stmt_code))
		else $error("executed statement was not echoed");

	AST_NO_ECHO: assert property (
		echo_valid |-> $past(echo_enable) == `SLSEL_ECHO_ON && $past(seq_running))
		else $error("echo issued with echo off or while idle");

	AST_LEVEL_NO_RESUME: assert property (
		seq_running && start_rise && start_action_mode == `SLSEL_MODE_LEVEL |=> s_no_launch)
		else $error("level mode start edge restarted or resumed");

	AST_IDLE_ABORT_BLOCKS: assert property (
		!seq_running && abort_any |=> !seq_start && !seq_running)
		else $error("launch taken while abort was held");

	AST_RESUME_SOURCE: assert property (
		seq_resume |-> $past(start_action_mode) == `SLSEL_MODE_EDGE && $past(seq_running))
		else $error("resume issued outside an edge mode run");

	AST_NUMBER_HOLDS: assert property (
		!seq_start |-> $stable(seq_number))
		else $error("sequence number moved without a launch");

endmodule : slsel_top

`default_nettype wire

// ---- design/slsel_defines.svh ----
// Constants of the sequence launch selector: input counts, widths, codes, sequence limit, stage reset value.
// Assumes inclusion by bare name from the selector's design files.
`ifndef SLSEL_DEFINES_SVH
`define SLSEL_DEFINES_SVH

`define SLSEL_NUM_INPUTS   9
`define SLSEL_SEL_BITS     7
`define SLSEL_ASSIGN_W     4
`define SLSEL_ASSIGN_NONE  4'h0
`define SLSEL_MODE_EDGE    1'b0
`define SLSEL_MODE_LEVEL   1'b1
`define SLSEL_ECHO_ON      1'b1
`define SLSEL_SEQ_MAX      7'h63
`define SLSEL_STMT_W       16
`define SLSEL_RST_STAGE    1'b0

`endif

// ---- design/slsel_pkg.sv ----
// Types shared by the sequence launch selector modules.
// Assumes slsel_defines.svh for widths.
`include "slsel_defines.svh"

package slsel_pkg;

	typedef enum logic [0:0] {
		SLSEL_IDLE = 1'b0,
		SLSEL_RUN  = 1'b1
	} slsel_state_type;

	typedef logic [`SLSEL_ASSIGN_W-1:0] slsel_assign_type;

endpackage : slsel_pkg

// ---- design/slsel_sync_if.sv ----
// Carrier between the selector top and its input synchroniser.
// Assumes one clock domain; raw comes from pins, sync goes back resampled.
`timescale 1ns/10ps
`default_nettype none

interface slsel_sync_if #(
	parameter int W = 9
);
	logic [W-1:0] raw;
	logic [W-1:0] sync;

	modport sync_side (input raw, output sync);
	modport user_side (output raw, input sync);
endinterface : slsel_sync_if

`default_nettype wire

// ---- design/slsel_sync.sv ----
// Two-stage synchroniser for the general-purpose inputs.
// Assumes clk_sys and synchronous active-low resetn; no other reader of stage one.
`timescale 1ns/10ps
`default_nettype none

module slsel_sync
	import slsel_pkg::*;
#(
	parameter int W = 9
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Inputs and their resampled copy
	slsel_sync_if.sync_side io
);

	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} slsel_sync_state_type;

	slsel_sync_state_type state_r;
	slsel_sync_state_type state_nxt;

	initial begin
		if (W < 1) begin
			$error("slsel_sync: width must be at least one");
		end
	end

	always_comb begin
		state_nxt        = state_r;
		state_nxt.stage1 = io.raw;
		state_nxt.stage2 = state_r.stage1;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign io.sync = state_r.stage2;

	AST_SYNC_TWO_CYCLES: assert property (@(posedge clk_sys) disable iff (!resetn)
		$past(resetn, 2) |-> io.sync == $past(io.raw, 2))
		else $error("synchronised inputs do not lag raw inputs by two cycles");

endmodule : slsel_sync

`default_nettype wire

// ---- test/slsel_host_model.sv ----
// Host controller model: drives the start, abort and selection pins.
// Assumes the bench hands it levels; start on input nine, abort on input eight.
`timescale 1ns/10ps
`default_nettype none

module slsel_host_model (
	// Levels from the bench
	input  wire logic [6:0] sel_val,
	input  wire logic       start_lvl,
	input  wire logic       abort_lvl,
	// Pins toward the selector
	output logic      [8:0] gp_in
);
	logic [6:0] sel_pin;

	// Stored sequences stop at ninety-nine
	assign sel_pin = (sel_val > 7'h63) ? 7'h63 : sel_val;
	// Start kept clear of the selection inputs
	assign gp_in   = {start_lvl, abort_lvl, sel_pin};
endmodule : slsel_host_model

`default_nettype wire

// ---- test/slsel_top_tb_top.sv ----
// Bench of the sequence launch selector: pin, terminal and echo traffic.
// Assumes slsel_host_model on the pins; results judged against a queue of notes.
`timescale 1ns/10ps
`default_nettype none
`include "slsel_defines.svh"

module slsel_top_tb_top;
	import slsel_pkg::*;

	logic        clk_sys, resetn, start_lvl, abort_lvl, mode, echo_en;
	logic        run_req, abort_req, done, stmt_v, seq_start, seq_resume, seq_abort, seq_running, echo_valid;
	logic [6:0]  sel_val, run_seq, seq_number;
	logic [8:0]  gp_in, mask;
	logic [15:0] stmt_code, echo_code;
	logic [3:0]  start_asg, abort_asg;
	logic [31:0] lfsr_r;
	logic [19:0] exp_q[$];
	int          n_fail, samples_checked, i;

	slsel_host_model host_u (.sel_val(sel_val), .start_lvl(start_lvl), .abort_lvl(abort_lvl), .gp_in(gp_in));

	slsel_top dut_u (.clk_sys(clk_sys), .resetn(resetn), .gp_in(gp_in), .start_input_assign(start_asg),
		.abort_input_assign(abort_asg), .other_func_mask(mask), .start_action_mode(mode), .echo_enable(echo_en),
		.term_run_req(run_req), .term_run_seq(run_seq), .term_abort_req(abort_req), .seq_done(done),
		.stmt_valid(stmt_v), .stmt_code(stmt_code), .seq_start(seq_start), .seq_resume(seq_resume),
		.seq_abort(seq_abort), .seq_number(seq_number), .seq_running(seq_running),
		.echo_valid(echo_valid), .echo_code(echo_code));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic results();
		$display("Checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next

	task automatic note(input logic [19:0] got);
		logic [19:0] e;
		e = (exp_q.size() > 0) ? exp_q.pop_front() : 20'hfffff;
		samples_checked++;
		if (e !== got) begin
			n_fail++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, got);
		end
	endtask : note

	// Outputs settle after the rising edge; look at the falling one
	always @(negedge clk_sys) begin
		if (resetn) begin
			if (seq_start) note({4'h1, 9'h0, seq_number});
			if (seq_resume) note(20'h20000);
			if (seq_abort) note(20'h30000);
			if (echo_valid) note({4'h4, echo_code});
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] e);
		samples_checked++;
		if (got !== e) begin
			n_fail++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, got);
		end
	endtask : check

	task automatic drain(input string name);
		int k;
		for (k = 0; k < 20 && exp_q.size() > 0; k++) cyc(1);
		if (exp_q.size() > 0) begin
			n_fail++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp_q[0], 20'h0);
			results();
		end else begin
			cyc(4);
			$display("Test %s done", name);
		end
	endtask : drain

	task automatic pin_cycle(input logic [6:0] sel, input logic [8:0] m);
		logic [6:0] num;
		num = sel & ~m[6:0];
		mask = m;
		sel_val = sel;
		cyc(2);
		start_lvl = 1'b1;
		exp_q.push_back({4'h1, 9'h0, num});
		cyc(6);
		sel_val = ~sel;
		start_lvl = 1'b0;
		cyc(6);
		check(seq_running, 16'h1);
		check(seq_number, num);
		start_lvl = 1'b1;
		exp_q.push_back(20'h20000);
		cyc(6);
		abort_lvl = 1'b1;
		exp_q.push_back(20'h30000);
		cyc(6);
		abort_lvl = 1'b0;
		start_lvl = 1'b0;
		drain("edge");
	endtask : pin_cycle

	task automatic term_run(input logic [6:0] n, input bit go);
		run_req = 1'b1;
		run_seq = n;
		if (go) exp_q.push_back({4'h1, 9'h0, n});
		cyc(1);
		run_req = 1'b0;
		cyc(3);
	endtask : term_run

	initial begin
		resetn = 1'b0;
		{start_lvl, abort_lvl, run_req, abort_req, done, stmt_v, echo_en} = 7'h0;
		mode = `SLSEL_MODE_EDGE;
		sel_val = 7'h0;
		run_seq = 7'h0;
		mask = 9'h0;
		stmt_code = 16'h0;
		start_asg = 4'h9;
		abort_asg = 4'h8;
		lfsr_r = 32'h4d70;
		cyc(10);
		resetn = 1'b1;
		cyc(2);
		for (i = 0; i < 7; i++) pin_cycle(7'h1 << i, 9'h0);
		for (i = 0; i < 5; i++) begin
			lfsr_r = lfsr_next(lfsr_r);
			pin_cycle(7'(lfsr_r % 32'd100), lfsr_r[24:16] & 9'h07f);
		end
		mode = `SLSEL_MODE_LEVEL;
		mask = 9'h0;
		sel_val = 7'h63;
		cyc(2);
		start_lvl = 1'b1;
		exp_q.push_back({4'h1, 9'h0, 7'h63});
		cyc(6);
		start_lvl = 1'b0;
		exp_q.push_back(20'h30000);
		drain("level");
		// Start moved onto input seven, which then drops out of the number
		sel_val = 7'h05;
		cyc(3);
		start_asg = 4'h7;
		cyc(2);
		sel_val = 7'h45;
		exp_q.push_back({4'h1, 9'h0, 7'h05});
		cyc(6);
		abort_lvl = 1'b1;
		exp_q.push_back(20'h30000);
		cyc(6);
		abort_lvl = 1'b0;
		sel_val = 7'h0;
		drain("remap");
		start_asg = `SLSEL_ASSIGN_NONE;
		start_lvl = 1'b1;
		cyc(6);
		check(seq_running, 16'h0);
		start_lvl = 1'b0;
		cyc(4);
		start_asg = 4'h9;
		term_run(7'h2a, 1'b1);
		term_run(7'h11, 1'b0);
		check(seq_number, 16'h2a);
		abort_req = 1'b1;
		exp_q.push_back(20'h30000);
		cyc(1);
		abort_req = 1'b0;
		drain("terminal");
		term_run(7'h05, 1'b1);
		echo_en = `SLSEL_ECHO_ON;
		stmt_v = 1'b1;
		stmt_code = lfsr_r[15:0];
		exp_q.push_back({4'h4, lfsr_r[15:0]});
		cyc(1);
		echo_en = 1'b0;
		stmt_code = ~lfsr_r[15:0];
		cyc(1);
		stmt_v = 1'b0;
		done = 1'b1;
		cyc(1);
		done = 1'b0;
		cyc(3);
		check(seq_running, 16'h0);
		drain("echo");
		results();
	end
endmodule : slsel_top_tb_top

`default_nettype wire
